//--- common/fsd_consts.svh
// Timing counts, sector indices and codes for the flash front-end host.
`ifndef FSD_CONSTS_SVH
`define FSD_CONSTS_SVH
`define FSD_CLK_NS 100
`define FSD_T_ACC_NS 80
`define FSD_T_WP_NS 50
`define FSD_T_PWRUP_NS 50000
`define FSD_CEIL_CYC(t) (((t) + `FSD_CLK_NS - 1) / `FSD_CLK_NS)
`define FSD_ACC_CYC `FSD_CEIL_CYC(`FSD_T_ACC_NS)
`define FSD_WP_CYC `FSD_CEIL_CYC(`FSD_T_WP_NS)
`define FSD_PWRUP_CYC `FSD_CEIL_CYC(`FSD_T_PWRUP_NS)
`define FSD_SYNC_CYC 2
`define FSD_RD_CYC (`FSD_ACC_CYC + `FSD_SYNC_CYC)
`define FSD_ID_PROT 2'h2
`define FSD_SEC_LAST 5'h12
`define FSD_SEC_BIG0 5'h04
`define FSD_SEC_MID 5'h03
`endif

//--- common/fsd_pkg.sv
// Types shared by the flash front-end host modules.
package fsd_pkg;
   typedef enum logic [2:0] {
      FSD_OP_READ,
      FSD_OP_WRITE,
      FSD_OP_ID_ENTER,
      FSD_OP_ID_EXIT,
      FSD_OP_ID_READ
   } fsd_op_e;
   typedef struct packed {
      logic wr;
      logic vid;
      logic last;
      logic a_m1;
      logic [18:0] addr;
      logic [15:0] data;
   } fsd_cyc_s;
endpackage

//--- common/fsd_cyc_if.sv
// Carrier of one bus cycle between the sequencer and the pin engine.
`timescale 1ns/1ns
`default_nettype none
interface fsd_cyc_if;
   logic req;
   fsd_pkg::fsd_cyc_s cyc;
   logic byte_mode;
   logic done;
   logic [15:0] rdata;
   modport seq (output req, output cyc, output byte_mode,
                input done, input rdata);
   modport eng (input req, input cyc, input byte_mode,
                output done, output rdata);
endinterface
`default_nettype wire

//--- verilog/fsd_bus_cyc.sv
// Pin engine that runs one flash bus cycle on the device pins.
`timescale 1ns/1ns
`default_nettype none
`include "fsd_consts.svh"
module fsd_bus_cyc (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Cycle carrier.
   fsd_cyc_if.eng bus,
   // Device pins.
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic [18:0] o_addr,
   output logic o_vid,
   output logic [15:0] o_dq,
   output logic [15:0] o_dq_oe_n,
   input wire logic [15:0] i_dq
);
   typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_RECOV} fsd_bc_e;
   fsd_bc_e bc;
   fsd_bc_e next_bc;
   fsd_pkg::fsd_cyc_s cyc;
   fsd_pkg::fsd_cyc_s next_cyc;
   logic [1:0] cnt;
   logic [15:0] dq_s1;
   logic [15:0] dq_s2;
   logic [15:0] rdata;
   wire logic take = (bc == BC_IDLE) && bus.req;
   wire logic strobe_end = (bc == BC_STROBE) && (cnt == 2'h1);
   wire logic busy = (next_bc != BC_IDLE);
   wire logic drv = busy && next_cyc.wr;

   always_comb
   begin
      unique case (bc)
         BC_IDLE: next_bc = take ? BC_SETUP : BC_IDLE;
         BC_SETUP: next_bc = BC_STROBE;
         BC_STROBE: next_bc = strobe_end ? BC_RECOV : BC_STROBE;
         BC_RECOV: next_bc = BC_IDLE;
      endcase
   end

   assign next_cyc = take ? bus.cyc : cyc;

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         bc <= BC_IDLE;
         cnt <= 2'h0;
         cyc <= '0;
      end
      else
      begin
         bc <= next_bc;
         cyc <= next_cyc;
         if (bc == BC_SETUP)
            cnt <= cyc.wr ? 2'(`FSD_WP_CYC) : 2'(`FSD_RD_CYC);
         else if (bc == BC_STROBE)
            cnt <= cnt - 2'h1;
      end
   end

   // Every strobe comes from a flop and lasts whole clock cycles. [RL7]
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_ce_n <= 1'b1;
         o_oe_n <= 1'b1;
         o_we_n <= 1'b1;
         o_vid <= 1'b0;
         o_dq_oe_n <= 16'hFFFF;
      end
      else
      begin
         o_ce_n <= !busy || (next_bc == BC_RECOV); // [RL9]
         o_we_n <= !((next_bc == BC_STROBE) && next_cyc.wr); // [RL9]
         o_oe_n <= !((next_bc == BC_STROBE) && !next_cyc.wr); // [RL8]
         o_vid <= busy && next_cyc.vid; // [RL15]
         o_dq_oe_n[15] <= !(bus.byte_mode || drv); // [RL2]
         o_dq_oe_n[14:8] <= {7{!(drv && !bus.byte_mode)}};
         o_dq_oe_n[7:0] <= {8{!drv}};
      end
   end

   // The data pins pass two flops before the capture reads them.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         dq_s1 <= 16'h0000;
         dq_s2 <= 16'h0000;
         rdata <= 16'h0000;
      end
      else
      begin
         dq_s1 <= i_dq;
         dq_s2 <= dq_s1;
         if (strobe_end && !cyc.wr)
            rdata <= dq_s2;
      end
   end

   assign o_addr = cyc.addr;
   assign o_dq = {bus.byte_mode ? cyc.a_m1 : cyc.data[15], cyc.data[14:0]};
   assign bus.done = (bc == BC_RECOV);
   assign bus.rdata = rdata;
endmodule
`default_nettype wire

//--- verilog/fsd_host.sv
// Host controller for a bottom-boot flash front end with identification.
`timescale 1ns/1ns
`default_nettype none
`include "fsd_consts.svh"
// Operation
// RL1: Sector index decoded from A18..A12 in bottom-boot order, nineteen sectors.
// RL2: Byte mode uses A18 to A-1, word mode A18 to A0.
// RL3: Identification codes read on low data lines, by command or high voltage.
// RL4: High-voltage read: A9 qualified, A6 low, A1:A0 select the code.
// RL5: Protection check puts the sector address on the top address bits.
// RL6: Upper identification byte is used only in word organisation.
// RL7: Control pulses are whole-cycle flop outputs, never short glitches.
// RL8: Writes are inhibited unless chip and write enables low, output high.
// RL9: A write cycle drives chip and write enables low, output enable high.
// RL10: No write is issued while power comes up after reset.
// RL11: After reset the device is assumed to be in array-read mode.
// RL12: Identification entry writes the full unlock sequence first.
// RL13: Identification mode lasts until the reset command is written.
// RL14: Protect read at low address 02h gives 01h protected, 00h not.
// RL15: High voltage on A9 is a separate qualifier output, no commands.
module fsd_host #(
   parameter logic [18:0] P_UNLK1_ADDR = 19'h00555,
   parameter logic [18:0] P_UNLK2_ADDR = 19'h002AA,
   parameter logic [7:0] P_UNLK1_DATA = 8'hAA,
   parameter logic [7:0] P_UNLK2_DATA = 8'h55,
   parameter logic [7:0] P_ID_CMD = 8'h90,
   parameter logic [7:0] P_RESET_CMD = 8'hF0
) (
   // Clock and reset.
   input wire logic I_MCLK,
   input wire logic I_ARST_N,
   // User request.
   input wire logic I_REQ,
   input wire logic [2:0] I_OP,
   input wire logic [19:0] I_ADDR,
   input wire logic [15:0] I_WDATA,
   input wire logic [1:0] I_ID_SEL,
   input wire logic [4:0] I_SECTOR,
   input wire logic I_HV,
   input wire logic I_BYTE_MODE,
   // User answer.
   output logic O_READY,
   output logic O_DONE,
   output logic O_REFUSED,
   output logic [15:0] O_RDATA,
   output logic O_ID_MODE,
   output logic [4:0] O_SECTOR,
   output logic O_PROTECTED,
   // Device pins.
   output logic O_CE_N,
   output logic O_OE_N,
   output logic O_WE_N,
   output logic O_BYTE_N,
   output logic [18:0] O_ADDR,
   output logic O_A9_VID,
   output logic [15:0] O_DQ,
   output logic [15:0] O_DQ_OE_N,
   input wire logic [15:0] I_DQ
);
   typedef enum logic [1:0] {ST_PWRUP, ST_IDLE, ST_RUN} fsd_hst_e;
   fsd_hst_e st;
   fsd_hst_e next_st;
   logic [9:0] cnt;
   fsd_pkg::fsd_op_e op;
   logic [19:0] addr;
   logic [15:0] wdata;
   logic [1:0] sel;
   logic [4:0] sector;
   logic hv;
   logic byte_mode;
   logic [1:0] step;
   logic id_mode;
   fsd_cyc_if cif();

   // Maps A18..A12 to the sector index.
   function automatic logic [4:0] sector_of(input logic [6:0] hi);
      if (hi[6:3] != 4'h0)
         return {1'b0, hi[6:3]} + `FSD_SEC_MID;
      else if (hi[2])
         return `FSD_SEC_MID;
      else if (hi[1])
         return hi[0] ? 5'h02 : 5'h01;
      else
         return 5'h00;
   endfunction

   // Gives the A18..A12 pattern that selects a sector.
   function automatic logic [6:0] sector_hi(input logic [4:0] idx);
      logic [4:0] t;
      t = idx - `FSD_SEC_MID;
      if (idx >= `FSD_SEC_BIG0)
         return {t[3:0], 3'h0};
      else if (idx == `FSD_SEC_MID)
         return 7'h04;
      else if (idx == 5'h02)
         return 7'h03;
      else if (idx == 5'h01)
         return 7'h02;
      else
         return 7'h00;
   endfunction

   // Request decode.
   wire logic is_idr = (I_OP == fsd_pkg::FSD_OP_ID_READ);
   wire logic bad_op = (I_OP > fsd_pkg::FSD_OP_ID_READ);
   wire logic bad_id = is_idr && !I_HV && !id_mode; // [RL3]
   wire logic bad_wr = (I_OP == fsd_pkg::FSD_OP_WRITE) && id_mode; // [RL13]
   wire logic bad_sec = is_idr && (I_ID_SEL == `FSD_ID_PROT) &&
                        (I_SECTOR > `FSD_SEC_LAST);
   wire logic take = (st == ST_IDLE) && I_REQ;
   wire logic bad = bad_op || bad_id || bad_wr || bad_sec;
   wire logic start = take && !bad;
   wire logic [6:0] req_hi = I_BYTE_MODE ? I_ADDR[19:13] : I_ADDR[18:12];
   wire logic [4:0] req_sec = is_idr ? I_SECTOR : sector_of(req_hi); // [RL1]

   // Cycle selection.
   wire logic op_arr = (op == fsd_pkg::FSD_OP_READ) ||
                       (op == fsd_pkg::FSD_OP_WRITE);
   wire logic op_idr = (op == fsd_pkg::FSD_OP_ID_READ);
   wire logic op_ent = (op == fsd_pkg::FSD_OP_ID_ENTER);
   wire logic op_ext = (op == fsd_pkg::FSD_OP_ID_EXIT);
   wire logic [18:0] pin_addr = byte_mode ? addr[19:1] : addr[18:0]; // [RL2]
   wire logic pin_a_m1 = byte_mode && addr[0]; // [RL2]
   wire logic [4:0] id_sec = (sel == `FSD_ID_PROT) ? sector : 5'h00;
   wire logic [6:0] id_hi = sector_hi(id_sec); // [RL5]
   wire logic [18:0] id_addr = {id_hi, 2'h0, hv, 7'h00, sel}; // [RL4] [RL14]
   wire logic [18:0] cmd_addr = (step == 2'h1) ? P_UNLK2_ADDR : P_UNLK1_ADDR;
   wire logic [7:0] cmd_data = (step == 2'h0) ? P_UNLK1_DATA :
                               (step == 2'h1) ? P_UNLK2_DATA : P_ID_CMD;
   wire logic cyc_wr = !(op == fsd_pkg::FSD_OP_READ) && !op_idr;
   wire logic cyc_last = !op_ent || (step == 2'h2); // [RL12]
   wire logic [18:0] cyc_addr = op_arr ? pin_addr :
                                op_idr ? id_addr :
                                op_ent ? cmd_addr : 19'h00000;
   wire logic [15:0] cyc_data = (op == fsd_pkg::FSD_OP_WRITE) ? wdata :
                                op_ext ? {8'h00, P_RESET_CMD} :
                                {8'h00, cmd_data}; // [RL12]
   wire logic fin = (st == ST_RUN) && cif.done && cyc_last;
   wire logic [15:0] rd_word = byte_mode ? {8'h00, cif.rdata[7:0]} :
                               cif.rdata; // [RL6]

   assign cif.req = (st == ST_RUN);
   assign cif.byte_mode = byte_mode;
   assign cif.cyc = '{wr: cyc_wr,
                      vid: op_idr && hv, // [RL15]
                      last: cyc_last,
                      a_m1: op_arr && pin_a_m1,
                      addr: cyc_addr,
                      data: cyc_data};

   always_comb
   begin
      unique case (st)
         ST_PWRUP: next_st = (cnt == 10'h001) ? ST_IDLE : ST_PWRUP; // [RL10]
         ST_IDLE: next_st = start ? ST_RUN : ST_IDLE;
         ST_RUN: next_st = fin ? ST_IDLE : ST_RUN;
         default: next_st = ST_PWRUP;
      endcase
   end

   always_ff @(posedge I_MCLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         st <= ST_PWRUP;
         cnt <= 10'(`FSD_PWRUP_CYC); // [RL10]
         step <= 2'h0;
      end
      else
      begin
         st <= next_st;
         if (st == ST_PWRUP)
            cnt <= cnt - 10'h001;
         if (start)
            step <= 2'h0;
         else if (cif.done && !cyc_last)
            step <= step + 2'h1; // [RL12]
      end
   end

   always_ff @(posedge I_MCLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         op <= fsd_pkg::FSD_OP_READ;
         addr <= 20'h00000;
         wdata <= 16'h0000;
         sel <= 2'h0;
         sector <= 5'h00;
         hv <= 1'b0;
         byte_mode <= 1'b0;
      end
      else if (start)
      begin
         op <= fsd_pkg::fsd_op_e'(I_OP);
         addr <= I_ADDR;
         wdata <= I_WDATA;
         sel <= I_ID_SEL;
         sector <= I_SECTOR;
         hv <= I_HV;
         byte_mode <= I_BYTE_MODE;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         id_mode <= 1'b0; // [RL11]
         O_DONE <= 1'b0;
         O_REFUSED <= 1'b0;
         O_RDATA <= 16'h0000;
         O_SECTOR <= 5'h00;
         O_PROTECTED <= 1'b0;
      end
      else
      begin
         if (fin && op_ent)
            id_mode <= 1'b1; // [RL3]
         else if (fin && op_ext)
            id_mode <= 1'b0; // [RL13]
         O_DONE <= fin;
         O_REFUSED <= take && bad;
         if (fin && !cyc_wr)
            O_RDATA <= rd_word; // [RL3]
         if (start)
            O_SECTOR <= req_sec; // [RL1]
         if (fin && op_idr && (sel == `FSD_ID_PROT))
            O_PROTECTED <= cif.rdata[0]; // [RL14]
      end
   end

   fsd_bus_cyc u_eng (
      .i_clk(I_MCLK),
      .i_arst_n(I_ARST_N),
      .bus(cif.eng),
      .o_ce_n(O_CE_N),
      .o_oe_n(O_OE_N),
      .o_we_n(O_WE_N),
      .o_addr(O_ADDR),
      .o_vid(O_A9_VID),
      .o_dq(O_DQ),
      .o_dq_oe_n(O_DQ_OE_N),
      .i_dq(I_DQ)
   );

   assign O_READY = (st == ST_IDLE);
   assign O_ID_MODE = id_mode;
   assign O_BYTE_N = !byte_mode;
endmodule
`default_nettype wire

//--- verif/fsd_host_checker.sv
// Concurrent checks on the pins and handshake of the flash host.
`timescale 1ns/1ns
`default_nettype none
`include "fsd_consts.svh"
module fsd_host_checker (
   // Watched ports of the host.
   input wire logic I_MCLK,
   input wire logic I_ARST_N,
   input wire logic O_READY,
   input wire logic O_DONE,
   input wire logic O_REFUSED,
   input wire logic O_ID_MODE,
   input wire logic O_CE_N,
   input wire logic O_OE_N,
   input wire logic O_WE_N,
   input wire logic O_A9_VID,
   input wire logic [15:0] O_DQ_OE_N
);
   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (!I_ARST_N);
   logic [9:0] pwr;
   wire pwr_wait = pwr < 10'(`FSD_PWRUP_CYC);
   always_ff @(posedge I_MCLK or negedge I_ARST_N)
      if (!I_ARST_N)
         pwr <= 10'h000;
      else if (pwr_wait)
         pwr <= pwr + 10'h001;
   property p_inhibit; !O_OE_N |-> O_WE_N && &O_DQ_OE_N[14:0]; endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("write strobe or data drive during a read");
   property p_write; !O_WE_N |-> !O_CE_N && O_OE_N; endproperty
   a_write: assert property (p_write)
      else $error("write strobe without chip select or with read");
   property p_we_pulse; $fell(O_WE_N) |=> O_WE_N && O_CE_N; endproperty
   a_we_pulse: assert property (p_we_pulse)
      else $error("write strobe not a one cycle pulse");
   property p_oe_pulse;
      $fell(O_OE_N) |-> !O_OE_N [*3] ##1 O_OE_N && O_CE_N;
   endproperty
   a_oe_pulse: assert property (p_oe_pulse)
      else $error("read strobe not three cycles");
   property p_pwr; pwr_wait |-> O_CE_N && !O_READY; endproperty
   a_pwr: assert property (p_pwr)
      else $error("activity during the power-up wait");
   property p_refuse; O_REFUSED |-> O_READY && O_CE_N && $past(O_CE_N);
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("refused request touched the pins");
   property p_vid; $rose(O_A9_VID) |=> $fell(O_OE_N); endproperty
   a_vid: assert property (p_vid)
      else $error("high voltage read not followed by read strobe");
   property p_id_set; $rose(O_ID_MODE) |-> O_DONE; endproperty
   a_id_set: assert property (p_id_set)
      else $error("identification mode set without completion");
   c_write: cover property (!O_WE_N);
   c_vid: cover property ($rose(O_A9_VID));
   c_refuse: cover property (O_REFUSED);
endmodule
bind fsd_host fsd_host_checker chk_u (.I_MCLK, .I_ARST_N, .O_READY,
   .O_DONE, .O_REFUSED, .O_ID_MODE, .O_CE_N, .O_OE_N, .O_WE_N, .O_A9_VID,
   .O_DQ_OE_N);
`default_nettype wire

//--- verif/fsd_flash_model.sv
// Behavioural flash device answering the host pins.
`timescale 1ns/1ns
`default_nettype none
module fsd_flash_model #(
   // Identification codes; the values are arbitrary.
   parameter logic [7:0] P_MAKER = 8'h11,
   parameter logic [15:0] P_DEV = 16'h2244,
   parameter logic [7:0] P_CONT = 8'h66
) (
   // Device pins.
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic i_byte_n,
   input wire logic i_vid,
   input wire logic [18:0] i_addr,
   input wire logic [15:0] i_dq,
   output logic [15:0] o_dq
);
   logic [1:0] step = 2'h0;
   logic idm = 1'b0;
   logic ok;
   logic [15:0] idv;
   wire [6:0] t = i_addr[18:12];
   wire [4:0] sec = t[6:3] != 4'h0 ? {1'b0, t[6:3]} + 5'h03 :
      t[2] ? 5'h03 : {3'h0, t[1] ? (t[0] ? 2'h2 : 2'h1) : 2'h0};
   wire ids = idm || (i_vid && !i_addr[6]);
   wire [15:0] w = ids ? idv : i_addr[15:0] ^ 16'h3C5A;
   wire [7:0] lo = i_dq[15] && !i_byte_n && !ids ? w[15:8] : w[7:0];
   wire [15:0] v = i_byte_n ? w : {~w[15:8], lo};
   assign #80 o_dq = !i_ce_n && !i_oe_n ? v : ~v;
   always_comb
      case (i_addr[1:0])
         2'h0: idv = {8'h00, P_MAKER};
         2'h1: idv = P_DEV;
         2'h2: idv = {15'h0000, sec[0]};
         default: idv = {8'h00, P_CONT};
      endcase
   always @(negedge i_we_n)
      ok = !i_ce_n && i_oe_n && $time > 50000;
   always @(posedge i_we_n)
      if (ok)
         case (i_dq[7:0])
            8'hF0: {step, idm} <= 3'h0;
            8'hAA: step <= 2'h1;
            8'h55: step <= step == 2'h1 ? 2'h2 : 2'h0;
            8'h90: {step, idm} <= {2'h0, idm || step == 2'h2};
            default: step <= 2'h0;
         endcase
endmodule
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the flash front-end host.
`timescale 1ns/1ns
`default_nettype none
module tb;
   // Identification codes; the values are arbitrary.
   localparam logic [7:0] MK = 8'h11;
   localparam logic [15:0] DV = 16'h2244;
   localparam logic [7:0] CT = 8'h66;
   logic I_MCLK, I_ARST_N, I_REQ, I_HV, I_BYTE_MODE, O_READY, O_DONE;
   logic O_REFUSED, O_ID_MODE, O_PROTECTED, O_CE_N, O_OE_N, O_WE_N;
   logic O_BYTE_N, O_A9_VID;
   logic [2:0] I_OP;
   logic [19:0] I_ADDR, a;
   logic [15:0] I_WDATA, I_DQ, O_RDATA, O_DQ, O_DQ_OE_N;
   logic [1:0] I_ID_SEL;
   logic [4:0] I_SECTOR, O_SECTOR;
   logic [18:0] O_ADDR;
   logic [19:0] sq [9] = '{20'h555AA, 20'h2AA55, 20'h55590, 20'hFFF00,
      20'h000F0, 20'h555AA, 20'h2AA12, 20'h55590, 20'hFFF00};
   int num_errors, compares, i;
   fsd_host dut_u (.I_MCLK, .I_ARST_N, .I_REQ, .I_OP, .I_ADDR, .I_WDATA,
      .I_ID_SEL, .I_SECTOR, .I_HV, .I_BYTE_MODE, .O_READY, .O_DONE,
      .O_REFUSED, .O_RDATA, .O_ID_MODE, .O_SECTOR, .O_PROTECTED, .O_CE_N,
      .O_OE_N, .O_WE_N, .O_BYTE_N, .O_ADDR, .O_A9_VID, .O_DQ, .O_DQ_OE_N,
      .I_DQ);
   fsd_flash_model #(.P_MAKER(MK), .P_DEV(DV), .P_CONT(CT)) mdl_u (
      .i_ce_n(O_CE_N), .i_oe_n(O_OE_N), .i_we_n(O_WE_N), .i_byte_n(O_BYTE_N),
      .i_vid(O_A9_VID), .i_addr(O_ADDR), .i_dq(O_DQ), .o_dq(I_DQ));
   initial
   begin
      I_MCLK = 1'b0;
      forever #50 I_MCLK = ~I_MCLK;
   end
   function automatic logic [4:0] sec(input logic [6:0] t);
      if (t[6:3] != 4'h0)
         return {1'b0, t[6:3]} + 5'h03;
      return t[2] ? 5'h03 : {3'h0, t[1] ? (t[0] ? 2'h2 : 2'h1) : 2'h0};
   endfunction
   function automatic logic [15:0] arr(input logic [19:0] x, input logic b);
      logic [15:0] v;
      v = (b ? x[16:1] : x[15:0]) ^ 16'h3C5A;
      return b ? {8'h00, x[0] ? v[15:8] : v[7:0]} : v;
   endfunction
   function automatic logic [15:0] idv(input logic [1:0] s,
      input logic [4:0] n, input logic b);
      logic [15:0] v;
      v = s == 2'h0 ? {8'h00, MK} : s == 2'h1 ? DV :
         s == 2'h2 ? {15'h0000, n[0]} : {8'h00, CT};
      return b ? {8'h00, v[7:0]} : v;
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      compares++;
      if (g !== x)
      begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic test_done(input int t);
      num_errors += t;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic run(input logic [2:0] op, input logic [19:0] ad,
      input logic [15:0] w, input logic [1:0] s, input logic [4:0] n,
      input logic hv, input logic b);
      for (i = 0; i < 900 && O_READY !== 1'b1; i++)
         @(negedge I_MCLK);
      if (i == 900)
         test_done(1);
      @(posedge I_MCLK);
      {I_REQ, I_OP, I_ADDR, I_WDATA, I_ID_SEL, I_SECTOR, I_HV, I_BYTE_MODE}
         <= {1'b1, op, ad, w, s, n, hv, b};
      @(posedge I_MCLK);
      I_REQ <= 1'b0;
      for (i = 0; i < 20 && O_DONE !== 1'b1 && O_REFUSED !== 1'b1; i++)
         @(negedge I_MCLK);
      if (i == 20)
         test_done(1);
   endtask
   task automatic idrd(input logic [1:0] s, input logic [4:0] n,
      input logic hv, input logic b);
      run(3'h4, 20'($urandom), 16'($urandom), s, n, hv, b);
      chk(O_RDATA, idv(s, n, b));
      if (s == 2'h2)
         chk({O_PROTECTED, O_SECTOR}, {10'h000, n[0], n});
   endtask
   initial
   begin
      {I_ARST_N, I_REQ, I_OP, I_ADDR, I_WDATA} = '0;
      {I_ID_SEL, I_SECTOR, I_HV, I_BYTE_MODE} = '0;
      i = $urandom(7593);
      repeat (2) @(posedge I_MCLK);
      I_ARST_N <= 1'b1;
      @(negedge I_MCLK);
      chk({O_READY, O_CE_N, O_WE_N, O_OE_N, O_ID_MODE}, 16'h000E);
      for (int k = 0; k < 12; k++)
      begin
         a = k < 4 ? 20'h01FFF << (k * 4) : 20'($urandom);
         run(3'h0, a, 16'($urandom), 2'h0, 5'h00, 1'b0, k[0]);
         chk(O_RDATA, arr(a, k[0]));
         chk(16'(O_SECTOR), 16'(sec(k[0] ? a[19:13] : a[18:12])));
      end
      for (int k = 0; k < 27; k++)
         idrd(k < 8 ? k[1:0] : 2'h2, k < 8 ? 5'($urandom_range(18)) :
            5'(k - 8), 1'b1, k[2]);
      for (int k = 0; k < 5; k++)
      begin
         run(k < 3 ? 3'(k + 5) : 3'h4, 20'h00000, 16'h0000, 2'h2,
            k == 4 ? 5'h13 : 5'h00, k == 4, 1'b0);
         chk({O_REFUSED, O_READY, O_CE_N}, 16'h0007);
      end
      foreach (sq[k])
      begin
         a = {8'h00, sq[k][19:8]};
         run(a == 20'h00FFF ? 3'h0 : 3'h1, a == 20'h00FFF ? 20'h1 : a,
            {8'h00, sq[k][7:0]}, 2'h0, 5'h00, 1'b0, 1'b0);
         if (a == 20'h00FFF)
            chk(O_RDATA, k == 3 ? DV : arr(20'h1, 1'b0));
      end
      run(3'h2, 20'h0, 16'h0, 2'h0, 5'h00, 1'b0, 1'b0);
      chk(O_ID_MODE, 1);
      for (int k = 0; k < 8; k++)
         idrd(k[1:0], 5'($urandom_range(18)), 1'b0, k[2]);
      run(3'h1, 20'h0, 16'h00AA, 2'h0, 5'h00, 1'b0, 1'b0);
      chk(O_REFUSED, 1);
      run(3'h3, 20'h0, 16'h0, 2'h0, 5'h00, 1'b0, 1'b0);
      chk(O_ID_MODE, 0);
      run(3'h0, 20'h00002, 16'h0, 2'h0, 5'h00, 1'b0, 1'b0);
      chk(O_RDATA, arr(20'h00002, 1'b0));
      test_done(0);
   end
endmodule
`default_nettype wire
